// File: dbg_ctrl_model.sv
// partner model: external debug command controller on the test port
`timescale 1ns/1ns
module dbg_ctrl_model (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    logic tdo_s;  // tdo taken at the last rising edge

    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // ------------------------------------------------------------
    // one tck period; tck rests low between frames
    // ------------------------------------------------------------
    task automatic step(input logic m, input logic d);
        tms_o = m;
        tdi_o = d;
        #16 tck_o = 1'b1;
        tdo_s = tdo_i;
        #16 tck_o = 1'b0;
    endtask

    // tms pattern, lsb first; idle tdi flips so no stale bit lingers
    task automatic walk(input logic [7:0] pat, input int n);
        for (int i = 0; i < n; i++) begin
            step(pat[i], ~tdi_o);
        end
    endtask

    // five ones always reach reset, whatever state the port was in
    task automatic reset_tap();
        walk(8'h1F, 6);
    endtask

    // instruction scan, lsb first; status leaves while code enters
    task automatic ir_scan(input logic [3:0] code,
                           output logic [3:0] seen);
        walk(8'h03, 4);
        for (int i = 0; i < 4; i++) begin
            step(i == 3, code[i]);
            seen[i] = tdo_s;
        end
        walk(8'h01, 2);
    endtask

    // data scan, msb first; word only acts at update
    task automatic dr_scan(input logic [31:0] v, input int n);
        walk(8'h01, 3);
        for (int i = n - 1; i >= 0; i--) begin
            step(i == 0, v[i]);
        end
        walk(8'h01, 2);
    endtask
endmodule

// File: dbg_seq_pkg.sv
// package: constants and types of the debug entry/exit sequencer
// Summary of operation
// - bus word update restores fetch address, releases core
// - go-to address update releases core at address
// - debug-request instruction at Update-IR requests debug
// - debug-request code is 0111, status shifts out
// - Capture-IR loads core status into shifter
// - status bits read 11 while in debug
// - emulation-enable code 0110 enables module at Update-IR
// - preamble 01 precedes status on instruction scan
package dbg_seq_pkg;

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    localparam int         IR_W          = 4;
    localparam logic [3:0] IR_DEBUG_REQ  = 4'h7;  // debug request
    localparam logic [3:0] IR_EMU_EN     = 4'h6;  // emulation enable
    localparam logic [3:0] IR_RESET_VAL  = 4'hF;  // bypass after reset
    localparam logic [1:0] ST_DEBUG      = 2'h3;  // core in debug
    localparam logic [1:0] ST_NORMAL     = 2'h0;  // core running
    localparam logic [1:0] IR_PREAMBLE   = 2'h1;  // leaves first

    // ------------------------------------------------------------
    // debug command word and data words
    // ------------------------------------------------------------
    localparam int         CMD_W         = 8;
    localparam int         CMD_RD_BIT    = 7;     // 1 = read command
    localparam int         CMD_GO_BIT    = 6;     // go flag
    localparam int         CMD_EX_BIT    = 5;     // execute_flag
    localparam int         RS_W          = 5;     // register select
    localparam logic [4:0] RS_PDB        = 5'h0A; // pipeline word write
    localparam logic [4:0] RS_GOTO       = 5'h0C; // jump_target_write
    localparam int         WORD_W        = 24;
    localparam int         ADDR_W        = 16;
    localparam logic [7:0] ADDR_PAD      = 8'h00; // top of go-to word
    localparam logic [23:0] JUMP_OPCODE  = 24'h0AF080;

    // ------------------------------------------------------------
    // events raised in the test clock domain
    // ------------------------------------------------------------
    localparam int EV_DBGREQ = 0;  // debug request to core
    localparam int EV_IL     = 1;  // instruction latch write
    localparam int EV_RESUME = 2;  // bus word write, resume
    localparam int EV_GOTO   = 3;  // go-to address write
    localparam int EV_N      = 4;

    // test access port controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR,
        UPD_DR, SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

    // commands and words handed to the core
    typedef struct packed {
        logic                  debug_req;    // debug request pulse
        logic                  il_write;     // latch word valid pulse
        logic                  pdb_write;    // bus word valid pulse
        logic                  pab_drive;    // address bus restore pulse
        logic                  release_core; // leave debug pulse
        logic [WORD_W-1:0]     il;           // instruction_latch_word
        logic [WORD_W-1:0]     program_data_bus_word;          // program_data_bus_word
        logic [ADDR_W-1:0]     program_address_bus;          // program_address_bus
    } core_cmd_t;

endpackage

// File: debug_entry_exit_sequencer.sv
// module: debug entry and exit sequencer behind the test port
`timescale 1ns/1ns
module debug_entry_exit_sequencer (
    input  logic                   clk_sys_i,
    input  logic                   nrst_i,
    input  logic                   tck_i,
    input  logic                   tms_i,
    input  logic                   tdi_i,
    output logic                   tdo_o,
    output logic                   tdo_oe_o,
    input  logic                   core_in_debug_i,
    input  logic [15:0]            fetch_addr_i,
    output logic                   emu_enable_o,
    output dbg_seq_pkg::core_cmd_t core_cmd_o
);
    import dbg_seq_pkg::*;

    // ------------------------------------------------------------
    // declarations, test clock domain
    // ------------------------------------------------------------
    logic              nrst_m_q;     // reset sync first stage
    logic              nrst_t_q;     // reset in test clock domain
    tap_state_t        tap_q;        // port controller state
    tap_state_t        tap_d;
    logic [IR_W-1:0]   ir_sr_q;      // instruction shifter
    logic [IR_W-1:0]   ir_q;         // current instruction
    logic              emu_en_q;     // emulation module enabled
    logic [WORD_W-1:0] dr_sr_q;      // command/data shifter
    logic              byp_q;        // bypass cell
    logic [CMD_W-1:0]  cmd_q;        // last debug command
    logic              want_data_q;  // next scan is a data word
    logic [WORD_W-1:0] il_word_q;    // held latch word
    logic [WORD_W-1:0] pdb_word_q;   // held bus word
    logic [ADDR_W-1:0] goto_addr_q;  // held start address
    logic [EV_N-1:0]   ev_tog_q;     // event toggles
    logic              dbg_tck;      // core debug, synchronised
    logic [1:0]        stat_tck;     // core_status_bits
    logic              tdo_q;
    logic              tdo_oe_q;
    logic              rst_t;        // system reset in test clock domain
    logic              dr_sel;       // data path is the debug path
    logic              cmd_wr;

    // ------------------------------------------------------------
    // declarations, system clock domain
    // ------------------------------------------------------------
    logic [EV_N-1:0]   ev_p;         // one-cycle event pulses
    logic              dbg_q;        // core debug, registered
    logic [ADDR_W-1:0] fetch_save_q; // fetch_address_save_reg
    core_cmd_t         core_cmd_q;

    // ------------------------------------------------------------
    // test clock reset synchroniser
    // ------------------------------------------------------------
    // the system reset is caught here so the port leaves reset with
    // the chip even if the controller never walks through reset
    always_ff @(posedge tck_i) begin
        nrst_m_q <= nrst_i;
        nrst_t_q <= nrst_m_q;
    end

    assign rst_t = !nrst_t_q;

    // ------------------------------------------------------------
    // port controller
    // ------------------------------------------------------------
    // next state from the mode select line
    always_comb begin
        tap_d = TLR;
        case (tap_q)
            TLR:     tap_d = tms_i ? TLR    : RTI;
            RTI:     tap_d = tms_i ? SEL_DR : RTI;
            SEL_DR:  tap_d = tms_i ? SEL_IR : CAP_DR;
            CAP_DR:  tap_d = tms_i ? EX1_DR : SH_DR;
            SH_DR:   tap_d = tms_i ? EX1_DR : SH_DR;
            EX1_DR:  tap_d = tms_i ? UPD_DR : PAU_DR;
            PAU_DR:  tap_d = tms_i ? EX2_DR : PAU_DR;
            EX2_DR:  tap_d = tms_i ? UPD_DR : SH_DR;
            UPD_DR:  tap_d = tms_i ? SEL_DR : RTI;
            SEL_IR:  tap_d = tms_i ? TLR    : CAP_IR;
            CAP_IR:  tap_d = tms_i ? EX1_IR : SH_IR;
            SH_IR:   tap_d = tms_i ? EX1_IR : SH_IR;
            EX1_IR:  tap_d = tms_i ? UPD_IR : PAU_IR;
            PAU_IR:  tap_d = tms_i ? EX2_IR : PAU_IR;
            EX2_IR:  tap_d = tms_i ? UPD_IR : SH_IR;
            UPD_IR:  tap_d = tms_i ? SEL_DR : RTI;
            default: tap_d = TLR;
        endcase
    end

    // state register
    always_ff @(posedge tck_i) begin
        if (rst_t) begin
            tap_q <= TLR;
        end else begin
            tap_q <= tap_d;
        end
    end

    // ------------------------------------------------------------
    // instruction path
    // ------------------------------------------------------------
    assign stat_tck = dbg_tck ? ST_DEBUG : ST_NORMAL;

    // capture status, shift lsb first, update the instruction
    always_ff @(posedge tck_i) begin
        if (rst_t || tap_q == TLR) begin
            ir_sr_q <= IR_RESET_VAL;
            ir_q    <= IR_RESET_VAL;
        end else if (tap_q == CAP_IR) begin
            ir_sr_q <= {stat_tck, IR_PREAMBLE};
        end else if (tap_q == SH_IR) begin
            ir_sr_q <= {tdi_i, ir_sr_q[IR_W-1:1]};
        end else if (tap_q == UPD_IR) begin
            ir_q    <= ir_sr_q;
        end
    end

    // emulation module stays enabled until the port is reset
    always_ff @(posedge tck_i) begin
        if (rst_t || tap_q == TLR) begin
            emu_en_q <= 1'b0;
        end else if (tap_q == UPD_IR && ir_sr_q == IR_EMU_EN) begin
            emu_en_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    assign dr_sel = emu_en_q && (ir_q == IR_EMU_EN);
    assign cmd_wr = !dr_sr_q[CMD_RD_BIT];

    // shifter: msb first in, bits land at the low end; no capture
    // load, so a word is only what the controller shifted
    always_ff @(posedge tck_i) begin
        if (rst_t) begin
            dr_sr_q <= '0;
            byp_q   <= 1'b0;
        end else if (tap_q == SH_DR) begin
            dr_sr_q <= {dr_sr_q[WORD_W-2:0], tdi_i};
            byp_q   <= tdi_i;
        end else if (tap_q == CAP_DR) begin
            byp_q   <= 1'b0;
        end
    end

    // command then data word; both act only at Update-DR
    always_ff @(posedge tck_i) begin
        if (rst_t || tap_q == TLR) begin
            cmd_q       <= '0;
            want_data_q <= 1'b0;
        end else if (tap_q == UPD_DR && dr_sel) begin
            if (!want_data_q) begin
                cmd_q       <= dr_sr_q[CMD_W-1:0];
                want_data_q <= cmd_wr &&
                    (dr_sr_q[RS_W-1:0] == RS_PDB ||
                     dr_sr_q[RS_W-1:0] == RS_GOTO);
            end else begin
                want_data_q <= 1'b0;
            end
        end
    end

    // held words and event toggles; words stay put while the
    // system side samples them, since a new update is many test
    // clocks away
    always_ff @(posedge tck_i) begin
        if (rst_t) begin
            il_word_q   <= '0;
            pdb_word_q  <= '0;
            goto_addr_q <= '0;
            ev_tog_q    <= '0;
        end else if (tap_q == UPD_IR && ir_sr_q == IR_DEBUG_REQ) begin
            ev_tog_q[EV_DBGREQ] <= !ev_tog_q[EV_DBGREQ];
        end else if (tap_q == UPD_DR && dr_sel && want_data_q) begin
            if (cmd_q[RS_W-1:0] == RS_GOTO &&
                cmd_q[CMD_GO_BIT] && cmd_q[CMD_EX_BIT]) begin
                goto_addr_q       <= dr_sr_q[ADDR_W-1:0];
                ev_tog_q[EV_GOTO] <= !ev_tog_q[EV_GOTO];
            end else if (cmd_q[RS_W-1:0] == RS_PDB &&
                cmd_q[CMD_GO_BIT] && cmd_q[CMD_EX_BIT]) begin
                pdb_word_q          <= dr_sr_q;
                ev_tog_q[EV_RESUME] <= !ev_tog_q[EV_RESUME];
            end else if (cmd_q[RS_W-1:0] == RS_PDB &&
                !cmd_q[CMD_GO_BIT] && !cmd_q[CMD_EX_BIT]) begin
                il_word_q         <= dr_sr_q;
                ev_tog_q[EV_IL]   <= !ev_tog_q[EV_IL];
            end
            // go without execute runs one instruction: not handled
        end
    end

    // test data out changes on the falling edge, per the port
    always_ff @(negedge tck_i) begin
        if (rst_t) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_oe_q <= (tap_q == SH_IR) || (tap_q == SH_DR);
            if (tap_q == SH_IR) begin
                tdo_q <= ir_sr_q[0];
            end else if (dr_sel) begin
                tdo_q <= dr_sr_q[WORD_W-1];
            end else begin
                tdo_q <= byp_q;
            end
        end
    end

    // ------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------
    sync_2ff #(.W(1)) u_dbg_sync (
        .clk_i  (tck_i),
        .nrst_i (nrst_t_q),
        .d_i    (dbg_q),
        .q_o    (dbg_tck)
    );

    sync_2ff #(.W(1)) u_emu_sync (
        .clk_i  (clk_sys_i),
        .nrst_i (nrst_i),
        .d_i    (emu_en_q),
        .q_o    (emu_enable_o)
    );

    toggle_event_rx #(.N(EV_N)) u_ev_rx (
        .clk_i   (clk_sys_i),
        .nrst_i  (nrst_i),
        .tog_i   (ev_tog_q),
        .pulse_o (ev_p)
    );

    // ------------------------------------------------------------
    // system side: fetch address save
    // ------------------------------------------------------------
    // the address is caught on entry, before the core may move it
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            dbg_q        <= 1'b0;
            fetch_save_q <= '0;
        end else begin
            dbg_q <= core_in_debug_i;
            if (core_in_debug_i && !dbg_q) begin
                fetch_save_q <= fetch_addr_i;
            end
        end
    end

    // ------------------------------------------------------------
    // system side: commands to the core
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            core_cmd_q <= '0;
        end else begin
            core_cmd_q.debug_req <= ev_p[EV_DBGREQ];
            core_cmd_q.il_write  <= ev_p[EV_IL];
            core_cmd_q.pdb_write <= ev_p[EV_RESUME] | ev_p[EV_GOTO];
            core_cmd_q.pab_drive <= ev_p[EV_RESUME];
            core_cmd_q.release_core <= ev_p[EV_RESUME] |
                                       ev_p[EV_GOTO];
            if (ev_p[EV_IL]) begin
                core_cmd_q.il <= il_word_q;
            end
            if (ev_p[EV_RESUME]) begin
                core_cmd_q.program_data_bus_word <= pdb_word_q;
                core_cmd_q.program_address_bus <= fetch_save_q;
            end else if (ev_p[EV_GOTO]) begin
                core_cmd_q.program_data_bus_word <= {ADDR_PAD, goto_addr_q};
            end
        end
    end

    assign core_cmd_o = core_cmd_q;
    assign tdo_o      = tdo_q;
    assign tdo_oe_o   = tdo_oe_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_dbgreq_to_core: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ev_p[EV_DBGREQ] |=> core_cmd_q.debug_req ##1
        !core_cmd_q.debug_req)
        else $error("debug request not a single pulse");

    a_resume_pab: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ev_p[EV_RESUME] |=> core_cmd_q.pab_drive &&
        core_cmd_q.release_core && core_cmd_q.pdb_write &&
        core_cmd_q.program_address_bus == $past(fetch_save_q))
        else $error("fetch address not restored on resume");

    a_goto_release: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ev_p[EV_GOTO] |=> core_cmd_q.release_core &&
        !core_cmd_q.pab_drive &&
        core_cmd_q.program_data_bus_word[ADDR_W-1:0] == $past(goto_addr_q))
        else $error("go-to did not release at address");

    a_latch_write: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ev_p[EV_IL] |=> core_cmd_q.il_write &&
        !core_cmd_q.release_core && core_cmd_q.il == $past(il_word_q))
        else $error("latch word not delivered");

    a_capture_status: assert property (
        @(posedge tck_i) disable iff (rst_t)
        tap_q == CAP_IR |=> ir_sr_q[1:0] == IR_PREAMBLE &&
        ir_sr_q[3:2] == $past(stat_tck))
        else $error("status not captured with preamble");

    a_status_debug: assert property (
        @(posedge tck_i) disable iff (rst_t)
        dbg_tck && tap_q == CAP_IR |=> ir_sr_q[3:2] == ST_DEBUG)
        else $error("status not 11 in debug");

    a_req_toggle: assert property (
        @(posedge tck_i) disable iff (rst_t)
        tap_q == UPD_IR && ir_sr_q == IR_DEBUG_REQ |=>
        ev_tog_q[EV_DBGREQ] != $past(ev_tog_q[EV_DBGREQ]))
        else $error("debug request instruction ignored");

    a_emu_enable: assert property (
        @(posedge tck_i) disable iff (rst_t)
        tap_q == UPD_IR && ir_sr_q == IR_EMU_EN |=> emu_en_q)
        else $error("emulation not enabled");

    a_no_early_act: assert property (
        @(posedge tck_i) disable iff (rst_t)
        tap_q != UPD_DR |=> $stable(ev_tog_q[EV_N-1:EV_IL]))
        else $error("data acted on before update");

    c_resume: cover property (@(posedge clk_sys_i)
        core_cmd_q.pab_drive);
    c_goto_jump: cover property (@(posedge clk_sys_i)
        core_cmd_q.release_core && core_cmd_q.il == JUMP_OPCODE);
    c_dbg_req: cover property (@(posedge clk_sys_i)
        core_cmd_q.debug_req);
    c_status_11: cover property (@(posedge tck_i)
        tap_q == SH_IR && ir_sr_q[3:2] == ST_DEBUG);
endmodule

// File: debug_entry_exit_sequencer_test.sv
// testbench: debug entry, status polling, resume and new-program exits
`timescale 1ns/1ns
module debug_entry_exit_sequencer_test;
    import dbg_seq_pkg::*;
    typedef struct {
        logic [1:0]  pre;   // 0 none, 1 re-enter and enable, 2 request
        logic [7:0]  cmd;   // command word
        logic [23:0] data;  // data word
        int          n;     // data bits, 0 means no data scan
        logic [3:0]  exp;   // latch, bus word, address, release pulses
    } row_t;
    localparam logic [15:0] FETCH = 16'h1234;
    localparam logic [3:0]  ST_RUN = {ST_NORMAL, IR_PREAMBLE};
    localparam logic [3:0]  ST_DBG = {ST_DEBUG, IR_PREAMBLE};
    logic        clk_sys_i, nrst_i, tck, tms, tdi, tdo, tdo_oe, emu;
    logic        core_dbg = 1'b0;
    logic        clr = 1'b0;
    logic [4:0]  seen = '0;
    logic [3:0]  st;
    core_cmd_t   cmd;
    int          failures = 0;
    int          num_checks = 0;
    logic [15:0] fetch = FETCH;  // core fetch address, frozen in debug
    logic [15:0] held = '0;      // address while the core is stopped
    logic [23:0] want;           // expected bus word
    logic        tdo_line;       // tdo as the controller sees it
    row_t rows [8] = '{
        '{0, 8'h8B, 24'h0, 0, 4'h0},
        '{0, 8'h8A, 24'h0, 0, 4'h0},
        '{0, 8'h0A, 24'hA5C3E1, 24, 4'h8},
        '{0, 8'h6A, 24'h5A3C1E, 24, 4'h7},
        '{2, 8'h0A, 24'h123456, 24, 4'h0},
        '{1, 8'h4A, 24'h0F0F0F, 24, 4'h0},
        '{0, 8'h0A, JUMP_OPCODE, 24, 4'h8},
        '{0, 8'h6C, 24'h00BEEF, 16, 4'h5}
    };
    row_t        r;              // row under test

    debug_entry_exit_sequencer dut (
        .clk_sys_i      (clk_sys_i),
        .nrst_i         (nrst_i),
        .tck_i          (tck),
        .tms_i          (tms),
        .tdi_i          (tdi),
        .tdo_o          (tdo),
        .tdo_oe_o       (tdo_oe),
        .core_in_debug_i(core_dbg),
        .fetch_addr_i   (fetch),
        .emu_enable_o   (emu),
        .core_cmd_o     (cmd)
    );
    // a released tdo shows the inverse, so a sample out of shift shows up
    assign tdo_line = tdo_oe ? tdo : ~tdo;
    dbg_ctrl_model ctl (
        .tck_o (tck),
        .tms_o (tms),
        .tdi_o (tdi),
        .tdo_i (tdo_line)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // core stand-in: halts on request, runs again on release
    always @(posedge clk_sys_i) begin
        if (cmd.debug_req) core_dbg <= 1'b1;
        else if (cmd.release_core) core_dbg <= 1'b0;
        if (!core_dbg) fetch <= fetch + 16'h0001;
    end
    // pulses last one cycle, so collect them until cleared
    always @(posedge clk_sys_i) begin
        if (clr) seen <= '0;
        else seen <= seen | {cmd.debug_req, cmd.il_write, cmd.pdb_write,
                             cmd.pab_drive, cmd.release_core};
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic settle_clear();
        @(posedge clk_sys_i) #1 clr = 1'b1;
        @(posedge clk_sys_i) #1 clr = 1'b0;
    endtask
    // request debug and poll status from idle, at most 8 more times, until acknowledged
    task automatic enter_debug();
        ctl.ir_scan(IR_DEBUG_REQ, st);
        for (int i = 0; i < 8 && st !== {ST_DEBUG, IR_PREAMBLE}; i++) begin
            ctl.walk(8'h00, 4);
            ctl.ir_scan(IR_DEBUG_REQ, st);
        end
    endtask

    initial begin
        nrst_i = 1'b0;
        ctl.reset_tap();
        check(32'(|cmd), 32'h0, "command in reset");
        check(32'(emu), 32'h0, "enable in reset");
        check(32'(tdo_oe), 32'h0, "tdo drive in reset");
        @(posedge clk_sys_i) #1 nrst_i = 1'b1;
        ctl.reset_tap();
        settle_clear();
        ctl.ir_scan(IR_DEBUG_REQ, st);
        check(32'(st), 32'(ST_RUN), "status running");
        repeat (12) @(posedge clk_sys_i);
        check(32'(seen[4]), 32'h1, "debug request");
        enter_debug();
        check(32'(st), 32'(ST_DBG), "status in debug");
        ctl.ir_scan(IR_EMU_EN, st);
        repeat (12) @(posedge clk_sys_i);
        check(32'(emu), 32'h1, "emulation enable");
        // ordinary transfers, one row each
        foreach (rows[k]) begin
            r = rows[k];
            if (r.pre != 2'd0) enter_debug();
            if (r.pre == 2'd1) ctl.ir_scan(IR_EMU_EN, st);
            held = fetch;  // core stopped here, so its address is frozen
            want = r.data;
            if (r.n == 16) want = {ADDR_PAD, r.data[15:0]};
            settle_clear();
            ctl.dr_scan({24'h0, r.cmd}, 8);
            if (r.n > 0) ctl.dr_scan({8'h0, r.data}, r.n);
            repeat (12) @(posedge clk_sys_i);
            check(32'(seen[3:0]), 32'(r.exp), "pulse set");
            if (r.exp[3]) check(32'(cmd.il), 32'(r.data), "latch");
            if (r.exp[2]) check(32'(cmd.program_data_bus_word), 32'(want), "word");
            if (r.exp[1]) check(32'(cmd.program_address_bus), 32'(held), "addr");
        end
        // mid-run reset: outputs clear, no false pulse, data path refused
        @(posedge clk_sys_i) #1 nrst_i = 1'b0;
        ctl.reset_tap();
        check(32'(|cmd), 32'h0, "command in second reset");
        check(32'(emu), 32'h0, "enable in second reset");
        settle_clear();
        @(posedge clk_sys_i) #1 nrst_i = 1'b1;
        ctl.reset_tap();
        ctl.dr_scan({24'h0, 8'h0A}, 8);
        ctl.dr_scan({8'h0, JUMP_OPCODE}, 24);
        repeat (12) @(posedge clk_sys_i);
        check(32'(seen), 32'h0, "pulse after reset");
        ctl.ir_scan(IR_DEBUG_REQ, st);
        check(32'(st), 32'(ST_RUN), "status after reset");
        wrap_up();
    end
    initial begin
        #300000;
        failures++;
        wrap_up();
    end
endmodule

// File: sync_2ff.sv
// module: two-flop level synchroniser
`timescale 1ns/1ns
module sync_2ff #(
    parameter int W = 1
) (
    input  logic         clk_i,
    input  logic         nrst_i,
    input  logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;  // first stage, read only by q_q
    logic [W-1:0] q_q;     // settled copy

    // ------------------------------------------------------------
    // two stages, synchronous reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            q_q    <= '0;
        end else begin
            meta_q <= d_i;
            q_q    <= meta_q;
        end
    end

    assign q_o = q_q;
endmodule

// File: toggle_event_rx.sv
// module: toggle-to-pulse event receiver across clock domains
`timescale 1ns/1ns
module toggle_event_rx #(
    parameter int N = 1
) (
    input  logic         clk_i,
    input  logic         nrst_i,
    input  logic [N-1:0] tog_i,
    output logic [N-1:0] pulse_o
);
    logic [N-1:0] tog_s;   // synchronised toggles
    logic [N-1:0] last_q;  // previous settled toggles

    sync_2ff #(.W(N)) u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (tog_i),
        .q_o    (tog_s)
    );

    // ------------------------------------------------------------
    // one edge detector per event
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ev
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    last_q[g] <= 1'b0;
                end else begin
                    last_q[g] <= tog_s[g];
                end
            end
            // a change of level marks exactly one event
            assign pulse_o[g] = tog_s[g] ^ last_q[g];
        end
    endgenerate
endmodule
